// [verilog/isc_slave_end.sv]
// slave end: i2c slave fsm, general call decode, scl stretching, control/status registers
// assumes it is clocked by the link clock and reached only through the link interface
//
// Behaviour
// - stretch bit set, scl low: hold low
// - stretch bit set, scl high: hold after fall
// - early select: transmit request after scl rise
// - early clear: transmit request after scl fall
// - clear bit wipes general call flag, kind
// - software writes clear bit only to clear
// - both enables: data byte against alternate id
// - software keeps alternate id lsb one
// - call enable: ack address zero, take byte
// - command 0x06 resets the slave interface
// - software reprograms own address after call
// - control bit one always zero
// - slave enable bit gates slave mode
// - 16-bit status register, resets to zero
// - call kind coding 00/01/10/11
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
module isc_slave_end (
	input wire logic sys_rst_in,
	isc_link_if.dev lk,
	output logic tx_request_out,
	output logic slave_active_out
);
	import isc_pkg::*;

	typedef enum logic [2:0] {D_IDLE, D_ADDR, D_ACKA, D_RX, D_ACKR, D_TX, D_ACKT} isc_dev_state_type;

	isc_dev_state_type st;
	logic scl_s1, scl_s2, scl_s3;
	logic sda_s1, sda_s2, sda_s3;
	logic req_s1, req_s2, req_s3;
	logic req_edge;
	logic scl_rise, scl_fall, start_c, stop_c;
	logic [15:0] ctrl;
	logic [7:0] alt_id;
	logic [6:0] own_addr;
	logic [7:0] tx_byte;
	logic [7:0] rx_byte;
	logic ack_tgl;
	logic [15:0] rdata;
	logic hold;
	logic sda_oe;
	logic [3:0] cnt;
	logic [7:0] sh;
	logic rw, is_gc, gc_reset;
	logic f_gc, f_txreq, f_stop, f_rep, f_start;
	isc_gc_kind_type gc_kind;
	logic ev_match, ev_stop, ev_rep, ev_gc, ev_txreq, ev_reset;
	isc_gc_kind_type ev_kind;
	logic [15:0] status_word;
	logic [15:0] rd_mux;
	logic wr_ctrl, wr_stat, rd_stat, wr_data, gc_clr;
	logic [15:0] stat_clr;

	always_ff @(posedge lk.link_clk or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			{scl_s1, scl_s2, scl_s3} <= 3'h7;
			{sda_s1, sda_s2, sda_s3} <= 3'h7;
			{req_s1, req_s2, req_s3} <= 3'h0;
		end else begin
			scl_s1 <= lk.scl;
			scl_s2 <= scl_s1;
			scl_s3 <= scl_s2;
			sda_s1 <= lk.sda;
			sda_s2 <= sda_s1;
			sda_s3 <= sda_s2;
			req_s1 <= lk.req_tgl;
			req_s2 <= req_s1;
			req_s3 <= req_s2;
		end
	end

	assign req_edge = req_s2 ^ req_s3;
	assign scl_rise = scl_s2 & ~scl_s3;
	assign scl_fall = ~scl_s2 & scl_s3;
	assign start_c = scl_s2 & scl_s3 & ~sda_s2 & sda_s3;
	assign stop_c = scl_s2 & scl_s3 & sda_s2 & ~sda_s3;

	assign wr_ctrl = req_edge & lk.req_we & (lk.req_idx == IDX_CONTROL);
	assign wr_stat = req_edge & lk.req_we & (lk.req_idx == IDX_STATUS);
	assign rd_stat = req_edge & ~lk.req_we & (lk.req_idx == IDX_STATUS);
	assign wr_data = req_edge & lk.req_we & (lk.req_idx == IDX_DATA);
	// clear acts only on the write carrying it
	assign gc_clr = wr_ctrl & lk.req_wdata[CB_GC_CLR];
	assign stat_clr = wr_stat ? lk.req_wdata : 16'h0000;

	assign status_word = {1'b0, f_start, f_rep, 2'b00, f_stop, gc_kind, 6'h00, f_txreq, f_gc};

	always_comb begin
		case (lk.req_idx)
			IDX_CONTROL: rd_mux = ctrl;
			IDX_STATUS: rd_mux = status_word;
			IDX_ALT_ID: rd_mux = {8'h00, alt_id};
			IDX_OWN_ADDR: rd_mux = {9'h000, own_addr};
			IDX_DATA: rd_mux = {8'h00, rx_byte};
			default: rd_mux = 16'h0000;
		endcase
	end

	// register handshake: request data is held stable by the host until the ack toggles
	always_ff @(posedge lk.link_clk or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			ack_tgl <= 1'b0;
			rdata <= 16'h0000;
			ctrl <= CONTROL_RESET;
			alt_id <= ALT_ID_RESET;
			own_addr <= OWN_ADDR_RESET;
			tx_byte <= 8'h00;
		end else if (req_edge) begin
			ack_tgl <= ~ack_tgl;
			rdata <= rd_mux;
			if (lk.req_we) begin
				case (lk.req_idx)
					// reserved and clear bits never stored
					IDX_CONTROL: ctrl <= lk.req_wdata & CONTROL_KEEP_MASK;
					IDX_ALT_ID: alt_id <= lk.req_wdata[7:0];
					IDX_OWN_ADDR: own_addr <= lk.req_wdata[6:0];
					IDX_DATA: tx_byte <= lk.req_wdata[7:0];
					default: ;
				endcase
			end
		end
	end

	// sticky status except the start and repeat flags; a hardware set wins over a same-cycle clear
	always_ff @(posedge lk.link_clk or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			f_gc <= 1'b0;
			gc_kind <= GC_NONE;
			f_txreq <= 1'b0;
			f_stop <= 1'b0;
			f_start <= 1'b0;
			f_rep <= 1'b0;
		end else begin
			if (ev_gc)
				f_gc <= 1'b1;
			else if (gc_clr || stat_clr[SB_GC_FLAG])
				f_gc <= 1'b0;
			// kind kept across a reset command
			if (ev_gc)
				gc_kind <= ev_kind;
			else if (gc_clr)
				gc_kind <= GC_NONE;
			if (ev_txreq)
				f_txreq <= 1'b1;
			else if (wr_data || stat_clr[SB_TX_REQ])
				f_txreq <= 1'b0;
			// stop flag also clears on a status read
			if (ev_stop)
				f_stop <= 1'b1;
			else if (rd_stat || stat_clr[SB_STOP])
				f_stop <= 1'b0;
			if (ev_match)
				f_start <= 1'b1;
			else if (ev_stop || ev_reset || !ctrl[CB_SLAVE_EN])
				f_start <= 1'b0;
			if (ev_rep)
				f_rep <= 1'b1;
			else if (ev_stop || ev_reset || !ctrl[CB_SLAVE_EN])
				f_rep <= 1'b0;
		end
	end

	// hold scl low while stretch bit set
	always_ff @(posedge lk.link_clk or posedge sys_rst_in) begin
		if (sys_rst_in)
			hold <= 1'b0;
		else if (!ctrl[CB_STRETCH])
			hold <= 1'b0;
		else if (!scl_s2)
			hold <= 1'b1;
	end

	always_ff @(posedge lk.link_clk or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			st <= D_IDLE;
			cnt <= 4'h0;
			sh <= 8'h00;
			rw <= 1'b0;
			is_gc <= 1'b0;
			gc_reset <= 1'b0;
			sda_oe <= 1'b0;
			rx_byte <= 8'h00;
			ev_match <= 1'b0;
			ev_stop <= 1'b0;
			ev_rep <= 1'b0;
			ev_gc <= 1'b0;
			ev_kind <= GC_NONE;
			ev_txreq <= 1'b0;
			ev_reset <= 1'b0;
		end else begin
			ev_match <= 1'b0;
			ev_stop <= 1'b0;
			ev_rep <= 1'b0;
			ev_gc <= 1'b0;
			ev_txreq <= 1'b0;
			ev_reset <= 1'b0;
			if (!ctrl[CB_SLAVE_EN]) begin
				st <= D_IDLE;
				sda_oe <= 1'b0;
			end else if (start_c) begin
				st <= D_ADDR;
				cnt <= 4'h0;
				sda_oe <= 1'b0;
				ev_rep <= f_start;
			end else if (stop_c) begin
				st <= D_IDLE;
				sda_oe <= 1'b0;
				ev_stop <= f_start;
			end else begin
				case (st)
					D_ADDR: begin
						if (scl_rise) begin
							sh <= {sh[6:0], sda_s2};
							cnt <= cnt + 4'h1;
						end else if (scl_fall && cnt == 4'h8) begin
							if (sh[7:1] == own_addr) begin
								rw <= sh[0];
								is_gc <= 1'b0;
								sda_oe <= 1'b1;
								ev_match <= 1'b1;
								st <= D_ACKA;
							end else if (sh == GC_ADDR && ctrl[CB_GC_EN]) begin
								rw <= 1'b0;
								is_gc <= 1'b1;
								sda_oe <= 1'b1;
								ev_match <= 1'b1;
								st <= D_ACKA;
							end else begin
								st <= D_IDLE;
							end
						end
					end
					D_ACKA: begin
						if (scl_rise && rw && ctrl[CB_EARLY_TX])
							ev_txreq <= 1'b1;
						if (scl_fall) begin
							cnt <= 4'h0;
							if (rw) begin
								ev_txreq <= ~ctrl[CB_EARLY_TX];
								sh <= tx_byte;
								sda_oe <= ~tx_byte[7];
								st <= D_TX;
							end else begin
								sda_oe <= 1'b0;
								st <= D_RX;
							end
						end
					end
					D_RX: begin
						if (scl_rise) begin
							sh <= {sh[6:0], sda_s2};
							cnt <= cnt + 4'h1;
						end else if (scl_fall && cnt == 4'h8) begin
							rx_byte <= sh;
							sda_oe <= 1'b1;
							is_gc <= 1'b0;
							st <= D_ACKR;
							if (is_gc) begin
								// alternate id match, lsb kept one
								if (ctrl[CB_HGC_EN] && ctrl[CB_GC_EN] && sh == alt_id) begin
									ev_gc <= 1'b1;
									ev_kind <= GC_ALT_MATCH;
								// reset command, taken after the ack
								end else if (sh == GC_CMD_RESET) begin
									ev_gc <= 1'b1;
									ev_kind <= GC_RESET_PROG;
									gc_reset <= 1'b1;
								end else if (sh == GC_CMD_PROG) begin
									ev_gc <= 1'b1;
									ev_kind <= GC_PROG;
								end
							end
						end
					end
					D_ACKR: begin
						if (scl_fall) begin
							sda_oe <= 1'b0;
							cnt <= 4'h0;
							if (gc_reset) begin
								gc_reset <= 1'b0;
								ev_reset <= 1'b1;
								st <= D_IDLE;
							end else begin
								st <= D_RX;
							end
						end
					end
					D_TX: begin
						if (scl_rise) begin
							cnt <= cnt + 4'h1;
						end else if (scl_fall) begin
							if (cnt == 4'h8) begin
								sda_oe <= 1'b0;
								st <= D_ACKT;
							end else begin
								sh <= {sh[6:0], 1'b0};
								sda_oe <= ~sh[6];
							end
						end
					end
					D_ACKT: begin
						if (scl_rise) begin
							// master nack ends the read
							if (sda_s2)
								st <= D_IDLE;
							else if (ctrl[CB_EARLY_TX])
								ev_txreq <= 1'b1;
						end else if (scl_fall) begin
							ev_txreq <= ~ctrl[CB_EARLY_TX];
							sh <= tx_byte;
							sda_oe <= ~tx_byte[7];
							cnt <= 4'h0;
							st <= D_TX;
						end
					end
					default: st <= D_IDLE;
				endcase
			end
		end
	end

	assign lk.dev_scl_oe = hold;
	assign lk.dev_sda_oe = sda_oe;
	assign lk.ack_tgl = ack_tgl;
	assign lk.rdata = rdata;
	assign tx_request_out = f_txreq;
	assign slave_active_out = f_start;
endmodule

// [verilog/isc_pkg.sv]
// shared constants for the slave link: register indices, bit positions, resets, timing
// assumes both ends and the bench import it before any other file
package isc_pkg;
	// printed address of the slave status register in the memory map
	localparam logic [31:0] SLAVE_BUS_STATUS_ADDR = 32'hFFFF_092C;
	// device register indices on the register handshake
	localparam logic [2:0] IDX_CONTROL = 3'h0;
	localparam logic [2:0] IDX_STATUS = 3'h1;
	localparam logic [2:0] IDX_ALT_ID = 3'h2;
	localparam logic [2:0] IDX_OWN_ADDR = 3'h3;
	localparam logic [2:0] IDX_DATA = 3'h4;
	// slave_control bit positions
	localparam int CB_SLAVE_EN = 0;
	localparam int CB_GC_EN = 2;
	localparam int CB_HGC_EN = 3;
	localparam int CB_GC_CLR = 4;
	localparam int CB_EARLY_TX = 5;
	localparam int CB_STRETCH = 6;
	// bits 15:11, 4 and 1 never stored
	localparam logic [15:0] CONTROL_KEEP_MASK = 16'h07ED;
	localparam logic [15:0] CONTROL_RESET = 16'h0000;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	// slave_bus_status bit positions
	localparam int SB_GC_FLAG = 0;
	localparam int SB_TX_REQ = 1;
	localparam int SB_STOP = 10;
	// general call address and command bytes
	localparam logic [7:0] GC_ADDR = 8'h00;
	localparam logic [7:0] GC_CMD_RESET = 8'h06;
	localparam logic [7:0] GC_CMD_PROG = 8'h04;
	localparam logic [7:0] ALT_ID_RESET = 8'h01;
	localparam logic [6:0] OWN_ADDR_RESET = 7'h50;
	typedef enum logic [1:0] {GC_NONE, GC_RESET_PROG, GC_PROG, GC_ALT_MATCH} isc_gc_kind_type;
	// host register byte offsets
	localparam logic [3:0] HA_I2C = 4'h0;
	localparam logic [3:0] HA_DEV = 4'h4;
	localparam logic [3:0] HA_STATUS = 4'h8;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// scl quarter period in ns and the host clock period
	localparam int SCL_QUARTER_NS = 500;
	localparam int CLK_PERIOD_NS = 50;
	localparam int QUARTER_CYCLES = SCL_QUARTER_NS / CLK_PERIOD_NS;
endpackage

// [verilog/isc_link_if.sv]
// link between host end and slave end: open-drain scl/sda, link clock, register handshake
// assumes oe high means pull the wire low; wire levels are resolved here
`timescale 1ns/1ps
interface isc_link_if;
	logic link_clk;
	logic host_scl_oe;
	logic host_sda_oe;
	logic dev_scl_oe;
	logic dev_sda_oe;
	logic scl;
	logic sda;
	logic req_tgl;
	logic req_we;
	logic [2:0] req_idx;
	logic [15:0] req_wdata;
	logic ack_tgl;
	logic [15:0] rdata;
	assign scl = ~(host_scl_oe | dev_scl_oe);
	assign sda = ~(host_sda_oe | dev_sda_oe);
	modport host (output link_clk, host_scl_oe, host_sda_oe, req_tgl, req_we, req_idx,
		req_wdata, input scl, sda, ack_tgl, rdata);
	modport dev (input link_clk, scl, sda, req_tgl, req_we, req_idx, req_wdata,
		output dev_scl_oe, dev_sda_oe, ack_tgl, rdata);
endinterface

// [verilog/isc_host_end.sv]
// host end: axi4-lite command registers, i2c master bit engine, link clock divider,
// register handshake to the slave end; assumes a single axi master and clk_in at 20 MHz
`timescale 1ns/1ps
module isc_host_end #(
	parameter int QUARTER = isc_pkg::QUARTER_CYCLES
) (
	input wire logic clk_in,
	input wire logic sys_rst_in,
	isc_link_if.host lk,
	input wire logic [3:0] s_axi_awaddr_in,
	input wire logic s_axi_awvalid_in,
	output logic s_axi_awready_out,
	input wire logic [31:0] s_axi_wdata_in,
	input wire logic [3:0] s_axi_wstrb_in,
	input wire logic s_axi_wvalid_in,
	output logic s_axi_wready_out,
	output logic [1:0] s_axi_bresp_out,
	output logic s_axi_bvalid_out,
	input wire logic s_axi_bready_in,
	input wire logic [3:0] s_axi_araddr_in,
	input wire logic s_axi_arvalid_in,
	output logic s_axi_arready_out,
	output logic [31:0] s_axi_rdata_out,
	output logic [1:0] s_axi_rresp_out,
	output logic s_axi_rvalid_out,
	input wire logic s_axi_rready_in
);
	import isc_pkg::*;

	typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} isc_host_state_type;

	isc_host_state_type hst;
	logic [3:0] aw_addr;
	logic [31:0] w_data;
	logic w_full;
	logic wr_fire, i2c_go, dev_go;
	logic lclk;
	logic scl_s1, scl_s2, sda_s1, sda_s2;
	logic ack_s1, ack_s2, ack_s3;
	logic [1:0] ph;
	logic [7:0] qcnt;
	logic [3:0] bitn;
	logic second, rnw, nack;
	logic [7:0] sh, data_byte, rd_byte;
	logic scl_oe, sda_oe;
	logic req_tgl, req_we, dev_busy;
	logic [2:0] req_idx;
	logic [15:0] req_wdata, dev_rdata;

	assign wr_fire = ~s_axi_awready_out & ~s_axi_wready_out & ~s_axi_bvalid_out;
	// partial-strobe writes are acknowledged but ignored
	assign i2c_go = wr_fire & w_full & (aw_addr == HA_I2C) & (hst == H_IDLE);
	assign dev_go = wr_fire & w_full & (aw_addr == HA_DEV) & ~dev_busy;

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			s_axi_awready_out <= 1'b1;
			s_axi_wready_out <= 1'b1;
			s_axi_bvalid_out <= 1'b0;
			s_axi_bresp_out <= RESP_OKAY;
			aw_addr <= 4'h0;
			w_data <= 32'h0000_0000;
			w_full <= 1'b0;
		end else begin
			if (s_axi_awvalid_in && s_axi_awready_out) begin
				aw_addr <= s_axi_awaddr_in;
				s_axi_awready_out <= 1'b0;
			end
			if (s_axi_wvalid_in && s_axi_wready_out) begin
				w_data <= s_axi_wdata_in;
				w_full <= &s_axi_wstrb_in;
				s_axi_wready_out <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid_out <= 1'b1;
				s_axi_bresp_out <= (aw_addr == HA_I2C || aw_addr == HA_DEV) ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid_out && s_axi_bready_in) begin
				s_axi_bvalid_out <= 1'b0;
				s_axi_awready_out <= 1'b1;
				s_axi_wready_out <= 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			s_axi_arready_out <= 1'b1;
			s_axi_rvalid_out <= 1'b0;
			s_axi_rdata_out <= 32'h0000_0000;
			s_axi_rresp_out <= RESP_OKAY;
		end else if (s_axi_arvalid_in && s_axi_arready_out) begin
			s_axi_arready_out <= 1'b0;
			s_axi_rvalid_out <= 1'b1;
			s_axi_rresp_out <= RESP_OKAY;
			case (s_axi_araddr_in)
				HA_STATUS: s_axi_rdata_out <= {dev_rdata, rd_byte, 5'h00, nack, dev_busy,
					hst != H_IDLE};
				HA_I2C, HA_DEV: s_axi_rdata_out <= 32'h0000_0000;
				default: begin
					s_axi_rdata_out <= 32'h0000_0000;
					s_axi_rresp_out <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid_out && s_axi_rready_in) begin
			s_axi_rvalid_out <= 1'b0;
			s_axi_arready_out <= 1'b1;
		end
	end

	// link clock is this clock halved; the slave end runs on it
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in)
			lclk <= 1'b0;
		else
			lclk <= ~lclk;
	end

	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			{scl_s1, scl_s2, sda_s1, sda_s2} <= 4'hF;
			{ack_s1, ack_s2, ack_s3} <= 3'h0;
		end else begin
			scl_s1 <= lk.scl;
			scl_s2 <= scl_s1;
			sda_s1 <= lk.sda;
			sda_s2 <= sda_s1;
			ack_s1 <= lk.ack_tgl;
			ack_s2 <= ack_s1;
			ack_s3 <= ack_s2;
		end
	end

	// toggle handshake; payload held until the ack toggle returns
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			req_tgl <= 1'b0;
			req_we <= 1'b0;
			req_idx <= 3'h0;
			req_wdata <= 16'h0000;
			dev_busy <= 1'b0;
			dev_rdata <= 16'h0000;
		end else if (dev_go) begin
			req_tgl <= ~req_tgl;
			req_we <= w_data[31];
			req_idx <= w_data[18:16];
			req_wdata <= w_data[15:0];
			dev_busy <= 1'b1;
		end else if (ack_s2 ^ ack_s3) begin
			dev_busy <= 1'b0;
			dev_rdata <= lk.rdata;
		end
	end

	// bit engine; high phase waits for scl to be seen high so stretching is honoured
	always_ff @(posedge clk_in or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			hst <= H_IDLE;
			ph <= 2'h0;
			qcnt <= 8'h00;
			bitn <= 4'h0;
			second <= 1'b0;
			rnw <= 1'b0;
			nack <= 1'b0;
			sh <= 8'h00;
			data_byte <= 8'h00;
			rd_byte <= 8'h00;
			scl_oe <= 1'b0;
			sda_oe <= 1'b0;
		end else if (hst == H_IDLE) begin
			if (i2c_go) begin
				hst <= H_START;
				ph <= 2'h0;
				qcnt <= 8'(QUARTER - 1);
				sh <= w_data[15:8];
				data_byte <= w_data[23:16];
				rnw <= w_data[8];
				second <= 1'b0;
				nack <= 1'b0;
				bitn <= 4'h0;
				sda_oe <= 1'b1;
			end
		end else if (!(ph == 2'h1 && hst != H_START && !scl_s2)) begin
			if (qcnt != 8'h00) begin
				qcnt <= qcnt - 8'h01;
			end else begin
				qcnt <= 8'(QUARTER - 1);
				ph <= ph + 2'h1;
				case (hst)
					H_START: begin
						if (ph == 2'h0) begin
							scl_oe <= 1'b1;
						end else begin
							hst <= H_BIT;
							ph <= 2'h0;
							sda_oe <= ~sh[7];
						end
					end
					H_BIT: begin
						case (ph)
							2'h0: scl_oe <= 1'b0;
							2'h1: begin
								if (bitn != 4'h8)
									sh <= {sh[6:0], sda_s2};
								else if (!(second && rnw))
									nack <= sda_s2;
							end
							2'h2: scl_oe <= 1'b1;
							default: begin
								if (bitn == 4'h8) begin
									if (second && rnw)
										rd_byte <= sh;
									if (second || nack) begin
										hst <= H_STOP;
										sda_oe <= 1'b1;
									end else begin
										second <= 1'b1;
										bitn <= 4'h0;
										sh <= data_byte;
										sda_oe <= rnw ? 1'b0 : ~data_byte[7];
									end
								end else begin
									bitn <= bitn + 4'h1;
									sda_oe <= (bitn == 4'h7 || (second && rnw)) ? 1'b0 : ~sh[7];
								end
							end
						endcase
					end
					H_STOP: begin
						if (ph == 2'h0) begin
							scl_oe <= 1'b0;
						end else begin
							sda_oe <= 1'b0;
							hst <= H_IDLE;
						end
					end
					default: hst <= H_IDLE;
				endcase
			end
		end
	end

	assign lk.link_clk = lclk;
	assign lk.host_scl_oe = scl_oe;
	assign lk.host_sda_oe = sda_oe;
	assign lk.req_tgl = req_tgl;
	assign lk.req_we = req_we;
	assign lk.req_idx = req_idx;
	assign lk.req_wdata = req_wdata;
endmodule

// [tb/isc_link_sva.sv]
// checker for the slave link: resolved wires and the slave end's drives
// assumes link_clk comes from the host end and sys_rst_in is the shared reset
`timescale 1ns/1ps
module isc_link_sva (
	input wire logic link_clk,
	input wire logic sys_rst_in,
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_scl_oe,
	input wire logic dev_sda_oe,
	input wire logic tx_request_out,
	input wire logic slave_active_out
);
	logic [5:0] scl_hist;
	logic [7:0] oe_hist;
	// the slave sees scl through synchronisers, so look a few cycles back
	always_ff @(posedge link_clk or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			scl_hist <= 6'h3F;
		end else begin
			scl_hist <= {scl_hist[4:0], scl};
		end
	end
	always_ff @(posedge link_clk or posedge sys_rst_in) begin
		if (sys_rst_in) begin
			oe_hist <= 8'h00;
		end else begin
			oe_hist <= {oe_hist[6:0], dev_sda_oe};
		end
	end
	default clocking cb @(posedge link_clk);
	endclocking
	default disable iff (sys_rst_in);
	sequence s_start;
		scl && $past(scl) && $fell(sda);
	endsequence
	sequence s_stop;
		scl && $past(scl) && $rose(sda);
	endsequence
	a_stretch_on_low: assert property (
		$rose(dev_scl_oe) |-> !(&scl_hist))
		else $error("slave pulled scl while scl stayed high");
	a_txreq_at_edge: assert property (
		$rose(tx_request_out) |-> (|scl_hist) && !(&scl_hist))
		else $error("transmit request away from an scl edge");
	a_sda_on_low: assert property (
		$changed(dev_sda_oe) |-> !scl)
		else $error("slave moved sda while scl high");
	a_no_dev_start: assert property (
		s_start |-> !dev_sda_oe)
		else $error("slave made a start condition");
	a_active_on_ack: assert property (
		$rose(slave_active_out) |-> (|oe_hist) or (##[0:8] dev_sda_oe))
		else $error("addressed flag without an ack");
	a_idle_after_stop: assert property (
		s_stop |-> ##[1:8] !slave_active_out)
		else $error("addressed flag kept after stop");
	a_scl_high_min: assert property (
		$rose(scl) |-> scl[*3])
		else $error("scl high phase cut short");
	a_ack_held: assert property (
		$rose(dev_sda_oe) |-> dev_sda_oe[*3])
		else $error("slave sda drive too short");
endmodule

// [tb/tb_top.sv]
// bench for the slave link: host end and slave end joined by the link interface
// assumes the package, interface and both ends compile first; drives the axi side
`timescale 1ns/1ps
module tb_top;
	import isc_pkg::*;
	logic clk_in = 1'b0;
	logic sys_rst_in = 1'b0;
	logic [3:0] awaddr = 4'h0;
	logic awvalid = 1'b0;
	logic [31:0] wdata = 32'h0000_0000;
	logic wvalid = 1'b0;
	logic [3:0] araddr = 4'h0;
	logic arvalid = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, tx_request, slave_active;
	logic [1:0] bresp, rresp;
	logic [31:0] rdata, st, v;
	int n_mismatch = 0;
	int n_checks = 0;
	logic [15:0] gc_ctl [3] = '{16'h0005, 16'h0005, 16'h000D};
	logic [7:0] gc_byte [3] = '{GC_CMD_PROG, GC_CMD_RESET, 8'h33};
	isc_gc_kind_type gc_kind [3] = '{GC_PROG, GC_RESET_PROG, GC_ALT_MATCH};
	isc_link_if lk();
	isc_host_end isc_host_end_i (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .lk(lk),
		.s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
		.s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wvalid),
		.s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
		.s_axi_bready_in(1'b1), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
		.s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
		.s_axi_rvalid_out(rvalid), .s_axi_rready_in(1'b1));
	isc_slave_end isc_slave_end_i (.sys_rst_in(sys_rst_in), .lk(lk),
		.tx_request_out(tx_request), .slave_active_out(slave_active));
	isc_link_sva isc_link_sva_i (.link_clk(lk.link_clk), .sys_rst_in(sys_rst_in),
		.scl(lk.scl), .sda(lk.sda), .dev_scl_oe(lk.dev_scl_oe), .dev_sda_oe(lk.dev_sda_oe),
		.tx_request_out(tx_request), .slave_active_out(slave_active));
	initial begin
		forever #25 clk_in = ~clk_in;
	end
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic timeout();
		n_mismatch++;
		tally_and_finish();
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// bready and rready stay high, so the answer is taken as soon as it shows
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		int n;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk_in);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (n == 100) timeout();
	endtask
	task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
		int n;
		araddr <= a;
		arvalid <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge clk_in);
			if (arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		d = rdata;
		if (n == 100) timeout();
	endtask
	task automatic poll(input int b);
		int n;
		for (n = 0; n < 1000; n++) begin
			axi_rd(HA_STATUS, st);
			if (st[b] === 1'b0) break;
		end
		if (n == 1000) timeout();
	endtask
	task automatic dev_wr(input logic [2:0] i, input logic [15:0] d);
		axi_wr(HA_DEV, {1'b1, 12'h000, i, d});
		poll(1);
	endtask
	task automatic dev_rd(input logic [2:0] i, output logic [31:0] d);
		axi_wr(HA_DEV, {1'b0, 12'h000, i, 16'h0000});
		poll(1);
		d = {16'h0000, st[31:16]};
	endtask
	task automatic i2c(input logic [7:0] a, input logic [7:0] d);
		axi_wr(HA_I2C, {8'h00, d, a, 8'h00});
		poll(0);
	endtask
	task automatic t_regs();
		dev_rd(IDX_CONTROL, v);
		check(v, 32'(CONTROL_RESET));
		dev_rd(IDX_STATUS, v);
		check(v, 32'(STATUS_RESET));
		dev_wr(IDX_CONTROL, 16'hFFFD);
		dev_rd(IDX_CONTROL, v);
		check(v, 32'(CONTROL_KEEP_MASK));
		dev_wr(IDX_CONTROL, 16'h0000);
		check(32'(bresp), 32'(RESP_OKAY));
		axi_rd(4'hC, v);
		check(32'(rresp), 32'(RESP_SLVERR));
		axi_wr(4'hC, 32'h0000_0000);
		check(32'(bresp), 32'(RESP_SLVERR));
		$display("test regs done");
	endtask
	task automatic t_enable();
		i2c(8'hA0, 8'hA5);
		check(32'(st[2]), 32'h0000_0001);
		dev_wr(IDX_CONTROL, 16'h0001);
		i2c(8'hA0, 8'hA5);
		check(32'(st[2]), 32'h0000_0000);
		dev_rd(IDX_DATA, v);
		check(v, 32'h0000_00A5);
		dev_rd(IDX_STATUS, v);
		check(v, 32'h0000_0400);
		check(32'(slave_active), 32'h0000_0000);
		$display("test enable done");
	endtask
	task automatic t_gcall();
		i2c(GC_ADDR, GC_CMD_PROG);
		check(32'(st[2]), 32'h0000_0001);
		dev_wr(IDX_ALT_ID, 16'h0033);
		for (int k = 0; k < 3; k++) begin
			dev_wr(IDX_CONTROL, gc_ctl[k]);
			i2c(GC_ADDR, gc_byte[k]);
			check(32'(st[2]), 32'h0000_0000);
			dev_rd(IDX_STATUS, v);
			check(v & 32'h0000_0301, {22'h0, gc_kind[k], 7'h00, 1'b1});
			dev_wr(IDX_CONTROL, gc_ctl[k] | 16'h0010);
			dev_rd(IDX_STATUS, v);
			check(v & 32'h0000_0301, 32'h0000_0000);
		end
		// software answers the call by moving the own address, then restores it
		dev_wr(IDX_OWN_ADDR, 16'h0051);
		i2c(8'hA2, 8'h11);
		check(32'(st[2]), 32'h0000_0000);
		dev_wr(IDX_OWN_ADDR, 16'(OWN_ADDR_RESET));
		$display("test general call done");
	endtask
	task automatic t_txreq(input logic early);
		int n;
		dev_wr(IDX_CONTROL, {10'h000, early, 5'h01});
		dev_wr(IDX_DATA, 16'h003C);
		axi_wr(HA_I2C, 32'h0000_A100);
		for (n = 0; n < 2000 && tx_request !== 1'b1; n++) @(posedge clk_in);
		if (n == 2000) timeout();
		check(32'(lk.scl), 32'(early));
		poll(0);
		check(32'(st[15:8]), 32'h0000_003C);
		dev_wr(IDX_STATUS, 16'h0002);
		check(32'(tx_request), 32'h0000_0000);
		$display("test transmit request done");
	endtask
	task automatic t_stretch();
		int n;
		dev_wr(IDX_CONTROL, 16'h0041);
		check(32'(lk.dev_scl_oe), 32'h0000_0000);
		axi_wr(HA_I2C, 32'h005A_A000);
		for (n = 0; n < 2000 && lk.dev_scl_oe !== 1'b1; n++) @(posedge clk_in);
		if (n == 2000) timeout();
		// far longer than any scl phase, so only a hold explains it
		repeat (400) @(posedge clk_in);
		check(32'(lk.scl), 32'h0000_0000);
		axi_rd(HA_STATUS, st);
		check(32'(st[0]), 32'h0000_0001);
		dev_wr(IDX_CONTROL, 16'h0001);
		poll(0);
		check(32'(lk.dev_scl_oe), 32'h0000_0000);
		check(32'(st[2]), 32'h0000_0000);
		$display("test stretch done");
	endtask
	initial begin
		// a declaration value makes no edge, so reset is raised by assignment
		sys_rst_in <= 1'b1;
		repeat (2) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		repeat (8) @(posedge clk_in);
		t_regs();
		t_enable();
		t_gcall();
		t_txreq(1'b1);
		t_txreq(1'b0);
		t_stretch();
		tally_and_finish();
	end
endmodule
